/* File: hw/scs_pkg.sv */
// constants, field positions and types shared by the clock source selector
// assumes a single 10 MHz pclk domain and an APB register port
package scs_pkg;

   // APB register byte offsets
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;

   // control register fields
   localparam int CTRL_REQ_BIT  = 0;
   localparam int CTRL_FDIV_LSB = 4;
   localparam int CTRL_NSEL_LSB = 8;
   localparam int CTRL_PSC_LSB  = 12;

   // status register fields
   localparam int ST_LOAD_BIT  = 0;
   localparam int ST_MISM_BIT  = 1;
   localparam int ST_MUL_BIT   = 2;
   localparam int ST_FAIL_BIT  = 3;
   localparam int ST_SWMON_LSB = 6;
   localparam int ST_PMODE_LSB = 8;
   localparam int ST_CUR_LSB   = 12;

   // interrupt status and mask bits
   localparam int IRQ_FAIL_BIT = 0;
   localparam int IRQ_SW_BIT   = 1;

   // configuration word 2 fields
   localparam int CFG_PMODE_LSB = 0;
   localparam int CFG_PINFN_BIT = 5;
   localparam int CFG_SWMON_LSB = 6;
   localparam int CFG_INIT_LSB  = 8;

   // reset values
   localparam logic [15:0] CFG_RST  = 16'hFFFF;
   localparam logic [2:0]  SRC_RST  = 3'h7;
   localparam logic [2:0]  FDIV_RST = 3'h0;
   localparam logic [2:0]  PSC_RST  = 3'h0;
   localparam logic [1:0]  MASK_RST = 2'h0;

   // source codes and primary submodes
   localparam logic [2:0] SRC_FRC     = 3'h0;
   localparam logic [2:0] SRC_FRC_MUL = 3'h1;
   localparam logic [2:0] SRC_PRI     = 3'h2;
   localparam logic [2:0] SRC_PRI_MUL = 3'h3;
   localparam logic [2:0] SRC_LOW_SPEED_CRYSTAL_OSC    = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_INTERNAL_RC    = 3'h5;
   localparam logic [2:0] SRC_RSVD    = 3'h6;
   localparam logic [2:0] SRC_FRC_DIV = 3'h7;
   localparam logic [1:0] PMODE_EXT   = 2'h0;
   localparam logic [1:0] PMODE_XTAL  = 2'h1;
   localparam logic [1:0] PMODE_HS    = 2'h2;
   localparam logic [1:0] PMODE_OFF   = 2'h3;

   // bit index of each oscillator in the src_clk input vector
   localparam logic [1:0] IDX_PRI  = 2'h0;
   localparam logic [1:0] IDX_LOW_SPEED_CRYSTAL_OSC = 2'h1;
   localparam logic [1:0] IDX_FRC  = 2'h2;
   localparam logic [1:0] IDX_LOW_POWER_INTERNAL_RC = 2'h3;

   localparam int         MUL_LOG2   = 2;
   localparam logic [2:0] INSTR_DIV  = 3'h1;
   localparam int         DIV_CNT_W  = 7;

   // monitor and switch timeout
   localparam int CLK_PERIOD_NS = 100;
   localparam int FAIL_TIME_NS  = 100000;
   localparam int FAIL_CYC      = FAIL_TIME_NS / CLK_PERIOD_NS;
   localparam int TMO_W         = 10;

   typedef enum logic {SW_IDLE, SW_WAIT} scs_sw_e;

endpackage

/* File: hw/scs_div_if.sv */
// tick divider hookup: enable pulse in, power-of-two ratio, pulse out
// assumes both ends run on the same pclk
`timescale 1ns/1ps
interface scs_div_if;
   logic       tick_in;
   logic [2:0] ratio;
   logic       tick_out;
   modport div  (input tick_in, input ratio, output tick_out);
   modport user (output tick_in, output ratio, input tick_out);
endinterface

/* File: hw/scs_div.sv */
// divides a one-cycle enable pulse by 2**ratio
// assumes tick_in is a one-cycle pulse on pclk
`timescale 1ns/1ps
module scs_div
   import scs_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   scs_div_if.div    d
);

   typedef struct packed {
      logic [DIV_CNT_W-1:0] cnt;
      logic                 out;
   } scs_div_st_s;

   scs_div_st_s q;
   scs_div_st_s n;

   function automatic logic [DIV_CNT_W-1:0] div_limit(input logic [2:0] r);
      div_limit = DIV_CNT_W'((8'h01 << r) - 8'h01);
   endfunction

   always_comb begin
      n = q;
      n.out = 1'b0;
      if (d.tick_in) begin
         if (q.cnt >= div_limit(d.ratio)) begin
            n.cnt = '0;
            n.out = 1'b1;
         end else begin
            n.cnt = q.cnt + 7'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign d.tick_out = q.out;

   property p_div_cause;
      @(posedge pclk) disable iff (!presetn)
      d.tick_out |-> $past(d.tick_in);
   endproperty
   a_div_cause: assert property (p_div_cause)
      else $error("divider pulse without input pulse");

endmodule

/* File: hw/scs_fail_safe_monitor.sv */
// fail-safe monitor: flags a source that stops ticking
// assumes tick is the synchronised edge pulse of the active source
`timescale 1ns/1ps
module scs_fail_safe_monitor
   import scs_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic enable,
   input  wire logic tick,
   output logic      fail
);

   typedef struct packed {
      logic [TMO_W-1:0] cnt;
      logic             fail;
   } scs_fail_safe_monitor_st_s;

   scs_fail_safe_monitor_st_s q;
   scs_fail_safe_monitor_st_s n;

   always_comb begin
      n = q;
      n.fail = 1'b0;
      if (!enable || tick) begin
         n.cnt = '0;
      end else if (q.cnt == TMO_W'(FAIL_CYC - 1)) begin
         n.cnt  = '0;
         n.fail = 1'b1;
      end else begin
         n.cnt = q.cnt + 10'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign fail = q.fail;

   property p_fail_quiet;
      @(posedge pclk) disable iff (!presetn)
      fail |-> $past(enable) && !$past(tick);
   endproperty
   a_fail_quiet: assert property (p_fail_quiet)
      else $error("clock fail flagged while source was ticking");

endmodule

/* File: hw/scs_top.sv */
// system clock source selector with APB registers
// assumes src_clk levels are asynchronous and much slower than pclk;
// cfg_word2 is static non-volatile configuration
// Function
// - exactly one of four oscillators feeds the system clock.
// - only primary and fast RC may use the 4x multiplier.
// - fast RC has an optional programmable divider.
// - instruction clock is the processor clock divided by two.
// - some primary modes put instruction clock on crystal output pin.
// - outside crystal modes a config bit decides crystal output pin use.
// - at reset source and mode come from config word 2 fields.
// - unprogrammed config starts on divided fast RC, code 111.
// - run-time switching only when switch/monitor upper bit is 0.
// - fail-safe monitor only when switch/monitor field is 00.
// - monitor detects failed clock and keeps system running.
// - initial source field decodes to eight documented codes; here code 110 is treated as reserved and falls back to fast RC.
// - primary submode from mode field; multiplied primary not high-speed.
// - internal and secondary modes expect primary mode field 11.
// - software postscaler slows processor clock relative to system clock.
// - with switching disabled, switch request ignored and held 0.
// - with switching disabled, new source ignored, current shows config.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module scs_top
   import scs_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [15:0] cfg_word2,
   input  wire logic [3:0]  src_clk,
   output logic             osc_tick,
   output logic             cpu_tick,
   output logic             instr_tick,
   output logic             crystal_out_pin,
   output logic             crystal_out_pin_oe_n,
   output logic             primary_osc_en,
   output logic             irq
);

   localparam int SW_MAX = FAIL_CYC;

   typedef struct packed {
      logic [3:0]       s1;
      logic [3:0]       s2;
      logic [3:0]       s3;
      logic [3:0]       filt;
      logic [15:0]      cfg;
      logic             loaded;
      logic [2:0]       cur;
      logic [2:0]       nsel;
      logic [2:0]       fdiv;
      logic [2:0]       psc;
      logic             req;
      scs_sw_e          sw;
      logic [TMO_W-1:0] sw_cnt;
      logic [15:0]      per_cnt;
      logic [15:0]      period;
      logic [15:0]      mul_cnt;
      logic [1:0]       mul_n;
      logic [1:0]       stat;
      logic [1:0]       mask;
      logic             osc_tick;
      logic             cpu_tick;
      logic             instr_tick;
      logic             pin_out;
      logic             pin_oe_n;
      logic             pri_en;
      logic             irq;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
   } scs_top_st_s;

   scs_top_st_s q;
   scs_top_st_s n;

   logic [3:0]  rise;
   logic        sel_rise;
   logic        mul_tick;
   logic        osc_src_tick;
   logic        sw_done;
   logic        fail_p;
   logic        sw_en;
   logic        fail_safe_monitor_en;
   logic        xtal_pin;
   logic [1:0]  pmode;
   logic [1:0]  swmon;
   logic [1:0]  clr;
   logic [1:0]  ev;
   logic [2:0]  init_code;
   logic [2:0]  tgt;
   logic [15:0] quarter;
   logic [31:0] rd;

   scs_div_if frc_if ();
   scs_div_if psc_if ();
   scs_div_if ins_if ();

   function automatic logic [2:0] sanitize(input logic [2:0] c,
                                           input logic [1:0] pm);
      sanitize = c;
      if (c == SRC_RSVD) begin
         sanitize = SRC_FRC;
      end else if ((c == SRC_PRI || c == SRC_PRI_MUL) && pm == PMODE_OFF) begin
         sanitize = SRC_FRC;
      end else if (c == SRC_PRI_MUL && pm == PMODE_HS) begin
         sanitize = SRC_PRI;
      end
   endfunction

   function automatic logic [1:0] base_idx(input logic [2:0] c);
      case (c)
         SRC_PRI, SRC_PRI_MUL: base_idx = IDX_PRI;
         SRC_LOW_SPEED_CRYSTAL_OSC:             base_idx = IDX_LOW_SPEED_CRYSTAL_OSC;
         SRC_LOW_POWER_INTERNAL_RC:             base_idx = IDX_LOW_POWER_INTERNAL_RC;
         default:              base_idx = IDX_FRC;
      endcase
   endfunction

   function automatic logic is_mul(input logic [2:0] c);
      is_mul = (c == SRC_FRC_MUL) || (c == SRC_PRI_MUL);
   endfunction

   function automatic logic is_pri(input logic [2:0] c);
      is_pri = (c == SRC_PRI) || (c == SRC_PRI_MUL);
   endfunction

   assign pmode     = q.cfg[CFG_PMODE_LSB +: 2];
   assign swmon     = q.cfg[CFG_SWMON_LSB +: 2];
   assign init_code = q.cfg[CFG_INIT_LSB +: 3];
   assign sw_en     = q.loaded && !swmon[1];
   assign fail_safe_monitor_en   = q.loaded && swmon == 2'h0;
   assign tgt       = sanitize(q.nsel, pmode);
   assign xtal_pin  = is_pri(q.cur) &&
                      (pmode == PMODE_XTAL || pmode == PMODE_HS);

   // fast RC divider, postscaler and the fixed halving to instruction rate
   assign frc_if.tick_in = rise[IDX_FRC];
   assign frc_if.ratio   = q.fdiv;
   assign psc_if.tick_in = osc_src_tick;
   assign psc_if.ratio   = q.psc;
   assign ins_if.tick_in = psc_if.tick_out;
   assign ins_if.ratio   = INSTR_DIV;

   scs_div u_frc_div (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (frc_if)
   );

   scs_div u_psc_div (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (psc_if)
   );

   scs_div u_ins_div (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (ins_if)
   );

   // monitor paused while a switch waits for its new source
   scs_fail_safe_monitor u_fail_safe_monitor (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (fail_safe_monitor_en && q.sw == SW_IDLE),
      .tick    (sel_rise),
      .fail    (fail_p)
   );

   always_comb begin
      n        = q;
      sw_done  = 1'b0;
      mul_tick = 1'b0;
      clr      = '0;
      rd       = '0;
      ev       = '0;

      // three-stage sampling; a level counts once stages two and three agree
      n.s1 = src_clk;
      n.s2 = q.s1;
      n.s3 = q.s2;
      for (int i = 0; i < 4; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            n.filt[i] = q.s3[i];
         end
      end
      rise     = n.filt & ~q.filt;
      sel_rise = rise[base_idx(q.cur)];

      // multiplier: learn the source period, then emit four evenly spaced
      // ticks per period; only as good as pclk resolution allows
      quarter = q.period >> MUL_LOG2;
      if (quarter == '0) begin
         quarter = 16'h0001;
      end
      if (sel_rise) begin
         n.per_cnt = '0;
         n.period  = q.per_cnt + 16'h0001;
         n.mul_cnt = '0;
         n.mul_n   = '0;
         mul_tick  = 1'b1;
      end else begin
         if (q.per_cnt != 16'hFFFF) begin
            n.per_cnt = q.per_cnt + 16'h0001;
         end
         n.mul_cnt = q.mul_cnt + 16'h0001;
         if (q.mul_n != 2'h3 && n.mul_cnt >= quarter) begin
            mul_tick  = 1'b1;
            n.mul_n   = q.mul_n + 2'h1;
            n.mul_cnt = '0;
         end
      end

      if (is_mul(q.cur)) begin
         osc_src_tick = mul_tick;
      end else if (q.cur == SRC_FRC_DIV) begin
         osc_src_tick = frc_if.tick_out;
      end else begin
         osc_src_tick = sel_rise;
      end
      n.osc_tick   = osc_src_tick && q.loaded;
      n.cpu_tick   = psc_if.tick_out;
      n.instr_tick = ins_if.tick_out;

      // capture the non-volatile configuration once after reset release
      if (!q.loaded) begin
         n.loaded = 1'b1;
         n.cfg    = cfg_word2;
         n.cur    = sanitize(cfg_word2[CFG_INIT_LSB +: 3],
                             cfg_word2[CFG_PMODE_LSB +: 2]);
         n.nsel   = n.cur;
      end

      // switch waits for the new source to tick before committing to it
      case (q.sw)
         SW_IDLE: begin
            if (q.req && sw_en) begin
               n.sw     = SW_WAIT;
               n.sw_cnt = '0;
            end
         end
         SW_WAIT: begin
            if (rise[base_idx(tgt)]) begin
               n.cur   = tgt;
               n.req   = 1'b0;
               n.sw    = SW_IDLE;
               sw_done = 1'b1;
            end else if (q.sw_cnt == TMO_W'(FAIL_CYC - 1)) begin
               n.req = 1'b0;
               n.sw  = SW_IDLE;
            end else begin
               n.sw_cnt = q.sw_cnt + 10'h001;
            end
         end
         default: begin
            n.sw = SW_IDLE;
         end
      endcase

      // APB: data prepared in setup, answered in the first access cycle
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      if (paddr == REG_CTRL) begin
         rd[CTRL_REQ_BIT]        = q.req;
         rd[CTRL_FDIV_LSB +: 3]  = q.fdiv;
         rd[CTRL_NSEL_LSB +: 3]  = q.nsel;
         rd[CTRL_PSC_LSB +: 3]   = q.psc;
      end else if (paddr == REG_STATUS) begin
         rd[ST_LOAD_BIT]        = q.loaded;
         rd[ST_MISM_BIT]        = (!is_pri(q.cur) && pmode != PMODE_OFF) ||
                                  init_code == SRC_RSVD;
         rd[ST_MUL_BIT]         = is_mul(q.cur);
         rd[ST_FAIL_BIT]        = q.stat[IRQ_FAIL_BIT];
         rd[ST_SWMON_LSB +: 2]  = swmon;
         rd[ST_PMODE_LSB +: 2]  = pmode;
         rd[ST_CUR_LSB +: 3]    = q.cur;
      end else if (paddr == REG_IRQ_STAT) begin
         rd[1:0] = q.stat;
      end else if (paddr == REG_IRQ_MASK) begin
         rd[1:0] = q.mask;
      end
      if (psel && !penable) begin
         n.pready  = 1'b1;
         n.prdata  = rd;
         n.pslverr = !(paddr == REG_CTRL || paddr == REG_STATUS ||
                       paddr == REG_IRQ_STAT || paddr == REG_IRQ_MASK);
      end
      if (psel && penable && q.pready && pwrite && !q.pslverr) begin
         if (paddr == REG_CTRL) begin
            // new source only steers a switch when switching is enabled
            n.nsel = pwdata[CTRL_NSEL_LSB +: 3];
            n.fdiv = pwdata[CTRL_FDIV_LSB +: 3];
            n.psc  = pwdata[CTRL_PSC_LSB +: 3];
            if (sw_en && pwdata[CTRL_REQ_BIT]) begin
               n.req = 1'b1;
            end
         end else if (paddr == REG_IRQ_STAT) begin
            clr = pwdata[1:0];
         end else if (paddr == REG_IRQ_MASK) begin
            n.mask = pwdata[1:0];
         end
      end

      // a failed source drops the system onto fast RC and keeps running
      if (fail_p) begin
         n.cur = SRC_FRC;
         n.req = 1'b0;
         n.sw  = SW_IDLE;
      end

      // hardware events win over a same-cycle clear
      ev[IRQ_FAIL_BIT] = fail_p;
      ev[IRQ_SW_BIT]   = sw_done;
      n.stat = (q.stat & ~clr) | ev;
      n.irq  = |(n.stat & n.mask);
      n.pri_en = q.loaded && pmode != PMODE_OFF;

      if (xtal_pin) begin
         n.pin_oe_n = 1'b1;
         n.pin_out  = 1'b0;
      end else if (!q.cfg[CFG_PINFN_BIT]) begin
         n.pin_oe_n = 1'b0;
         if (ins_if.tick_out) begin
            n.pin_out = !q.pin_out;
         end
      end else begin
         n.pin_oe_n = 1'b1;
         n.pin_out  = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q          <= '0;
         q.cfg      <= CFG_RST;
         q.cur      <= SRC_RST;
         q.nsel     <= SRC_RST;
         q.fdiv     <= FDIV_RST;
         q.psc      <= PSC_RST;
         q.mask     <= MASK_RST;
         q.sw       <= SW_IDLE;
         q.pin_oe_n <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign prdata               = q.prdata;
   assign pready               = q.pready;
   assign pslverr              = q.pslverr;
   assign osc_tick             = q.osc_tick;
   assign cpu_tick             = q.cpu_tick;
   assign instr_tick           = q.instr_tick;
   assign crystal_out_pin      = q.pin_out;
   assign crystal_out_pin_oe_n = q.pin_oe_n;
   assign primary_osc_en       = q.pri_en;
   assign irq                  = q.irq;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_sw_start;
      q.sw == SW_IDLE && q.req && sw_en && !fail_p;
   endsequence

   property p_no_reserved;
      q.cur != SRC_RSVD;
   endproperty
   a_no_reserved: assert property (p_no_reserved)
      else $error("reserved source selected");

   property p_boot_cfg;
      !q.loaded |-> q.cur == SRC_FRC_DIV;
   endproperty
   a_boot_cfg: assert property (p_boot_cfg)
      else $error("not on divided fast RC before configuration load");

   property p_load_src;
      $rose(q.loaded) |-> q.cur == sanitize(init_code, pmode);
   endproperty
   a_load_src: assert property (p_load_src)
      else $error("source after load does not follow configuration");

   property p_req_held;
      q.loaded && !sw_en |-> !q.req;
   endproperty
   a_req_held: assert property (p_req_held)
      else $error("switch request set while switching disabled");

   property p_cur_cfg;
      q.loaded && !sw_en |-> q.cur == sanitize(init_code, pmode);
   endproperty
   a_cur_cfg: assert property (p_cur_cfg)
      else $error("current source left configuration while locked");

   property p_switch;
      s_sw_start |=> q.sw == SW_WAIT ##[1:SW_MAX] q.sw == SW_IDLE;
   endproperty
   a_switch: assert property (p_switch)
      else $error("switch did not start or finish in time");

   property p_no_monitor;
      !fail_safe_monitor_en |-> !fail_p;
   endproperty
   a_no_monitor: assert property (p_no_monitor)
      else $error("clock fail raised with monitor disabled");

   property p_fail_frc;
      fail_p |=> q.cur == SRC_FRC && q.stat[IRQ_FAIL_BIT];
   endproperty
   a_fail_frc: assert property (p_fail_frc)
      else $error("clock fail did not fall back to fast RC");

   property p_pin_xtal;
      q.loaded && xtal_pin |=> q.pin_oe_n;
   endproperty
   a_pin_xtal: assert property (p_pin_xtal)
      else $error("crystal output pin driven in crystal mode");

   property p_pin_toggle;
      !q.pin_oe_n && $past(!q.pin_oe_n) && q.pin_out != $past(q.pin_out)
         |-> q.instr_tick;
   endproperty
   a_pin_toggle: assert property (p_pin_toggle)
      else $error("crystal output pin toggled off instruction tick");

endmodule

/* File: tb/scs_osc_model.sv */
// oscillator pin model: four free-running sources, each can be stopped
// assumes it is clocked by pclk and steered only by the bench
`timescale 1ns/1ps
module scs_osc_model #(parameter int HP [4] = '{4, 6, 4, 5})
(
   input  wire logic       pclk,
   input  wire logic [3:0] stop,
   output logic      [3:0] src_clk
);
   int cnt [4];
   initial begin
      src_clk = 4'h0;
      cnt = '{0, 0, 0, 0};
   end
   // a dead oscillator freezes its level, it does not float
   always @(posedge pclk) begin
      for (int k = 0; k < 4; k++) begin
         if (!stop[k]) begin
            cnt[k] <= (cnt[k] + 1) % HP[k];
            if (cnt[k] == HP[k] - 1) begin
               src_clk[k] <= ~src_clk[k];
            end
         end
      end
   end
endmodule

/* File: tb/tb_scs_top.sv */
// self-checking bench for the clock source selector
// assumes scs_pkg and the design files compile first
`timescale 1ns/1ps
module tb_scs_top;
   import scs_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
   logic pready, pslverr, rerr, osc_tick, cpu_tick, instr_tick, irq;
   logic crystal_out_pin, crystal_out_pin_oe_n, primary_osc_en, lastp;
   logic [15:0] cfg_word2 = CFG_RST;
   logic [3:0] src_clk, stop = 4'h0;
   logic [7:0] tbl [13] = '{8'hC0, 8'hC9, 8'hD0, 8'hD8, 8'hE4, 8'hED,
      8'hF0, 8'hFF, 8'h52, 8'h5B, 8'h9A, 8'h1B, 8'h12};
   int fail_count = 0, n_checks = 0, cyc = 0, o, c, i, p;
   always #50 pclk = ~pclk;
   scs_osc_model u_scs_osc_model (.pclk(pclk), .stop(stop),
      .src_clk(src_clk));
   scs_top u_scs_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cfg_word2(cfg_word2), .src_clk(src_clk), .osc_tick(osc_tick),
      .cpu_tick(cpu_tick), .instr_tick(instr_tick),
      .crystal_out_pin(crystal_out_pin),
      .crystal_out_pin_oe_n(crystal_out_pin_oe_n),
      .primary_osc_en(primary_osc_en), .irq(irq));
   task automatic tally_and_finish();
      if (fail_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic near(string nm, int v, int e);
      chk(nm, 32'(v >= e - 1 && v <= e + 1), 32'h0000_0001);
   endtask
   // holds the request until pready is seen high at an edge
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic do_reset(logic [15:0] cfg);
      @(posedge pclk);
      presetn <= 0;
      cfg_word2 <= cfg;
      repeat (3) @(posedge pclk);
      chk("oe_n_rst", crystal_out_pin_oe_n, 1);
      chk("irq_rst", irq, 0);
      presetn <= 1;
      repeat (2) @(posedge pclk);
   endtask
   task automatic cnt(int n);
      // let the synchroniser and the multiplier period settle first
      repeat (32) @(posedge pclk);
      o = 0;
      c = 0;
      i = 0;
      p = 0;
      lastp = crystal_out_pin;
      repeat (n) begin
         @(posedge pclk);
         o += osc_tick;
         c += cpu_tick;
         i += instr_tick;
         p += (crystal_out_pin !== lastp);
         lastp = crystal_out_pin;
      end
   endtask
   task automatic t_default();
      apb(0, REG_STATUS, 0);
      chk("status", rdata, 32'h0000_73C1);
      chk("pri_en", primary_osc_en, 0);
      chk("oe_n", crystal_out_pin_oe_n, 1);
      apb(0, REG_CTRL, 0);
      chk("ctrl", rdata, 32'h0000_0700);
      apb(0, REG_IRQ_MASK, 0);
      chk("mask", rdata, 0);
      apb(0, 8'h10, 0);
      chk("unmapped", {rerr, rdata[30:0]}, 32'h8000_0000);
   endtask
   task automatic t_locked();
      apb(1, REG_CTRL, 32'h0000_0201);
      apb(0, REG_CTRL, 0);
      chk("req_held", rdata[0], 0);
      repeat (40) @(posedge pclk);
      apb(0, REG_STATUS, 0);
      chk("cur_locked", rdata[14:12], 7);
   endtask
   task automatic t_decode();
      logic [7:0] t;
      foreach (tbl[k]) begin
         t = tbl[k];
         do_reset({5'h1F, t[5:3], 6'h3F, t[7:6]});
         apb(0, REG_STATUS, 0);
         chk("cur", rdata[14:12], t[2:0]);
         chk("mul", rdata[2], t[2:0] inside {1, 3});
         chk("mism", rdata[1], t[5:3] == 6);
         chk("pri_en", primary_osc_en, t[7:6] != 3);
      end
   endtask
   task automatic t_rates();
      do_reset(16'hF8DF);
      cnt(320);
      near("osc_frc", o, 40);
      near("instr", i, c / 2);
      chk("oe_n", crystal_out_pin_oe_n, 0);
      apb(1, REG_CTRL, 32'h0000_1000);
      cnt(320);
      near("cpu_psc", c, o / 2);
      do_reset(16'hF9DF);
      cnt(320);
      near("osc_mul", o, 160);
      do_reset(16'hFFDF);
      apb(1, REG_CTRL, 32'h0000_0720);
      cnt(320);
      near("osc_div", o, 10);
      do_reset(16'hFADC);
      cnt(320);
      chk("oe_n_ec", crystal_out_pin_oe_n, 0);
      near("pin", p, i);
      do_reset(16'hFADD);
      chk("oe_n_xt", crystal_out_pin_oe_n, 1);
   endtask
   // switch to the secondary source, then kill it
   task automatic t_switch(logic [15:0] cfg, logic [31:0] mask);
      do_reset(cfg);
      apb(1, REG_IRQ_MASK, mask);
      apb(1, REG_CTRL, 32'h0000_0401);
      for (int k = 0; k < 50; k++) begin
         apb(0, REG_CTRL, 0);
         if (rdata[0] === 1'b0) begin
            break;
         end
      end
      apb(0, REG_STATUS, 0);
      chk("cur_sw", rdata[14:12], 4);
      apb(0, REG_IRQ_STAT, 0);
      chk("stat_sw", rdata, 2);
      chk("irq_sw", irq, mask[1]);
      apb(1, REG_IRQ_STAT, 2);
      stop <= 4'h2;
      for (int k = 0; k < 1300; k++) begin
         @(posedge pclk);
         if (irq === 1'b1) begin
            break;
         end
      end
      apb(0, REG_STATUS, 0);
      chk("cur_fail", rdata[14:12], mask[0] ? 0 : 4);
      chk("cf", rdata[3], mask[0]);
      stop <= 4'h0;
      apb(1, REG_IRQ_STAT, 1);
      @(posedge pclk);
      chk("irq_clr", irq, 0);
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      repeat (2) @(posedge pclk);
      t_default();
      t_locked();
      t_decode();
      t_rates();
      t_switch(16'hF83F, 3);
      t_switch(16'hF87F, 0);
      tally_and_finish();
   end
endmodule
